// ### verilog/dsp_serial_port.sv
// serial dte port: configurable async receiver and transmitter with flow control
// assumes all inputs synchronous to ref_clk_in; line levels are logic levels (1 = mark)
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// receive fifo
// ----------------------------------------------------------------
module dsp_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [W-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [W-1:0] out_data_out
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;
   localparam int CW = AW + 1;
   logic [W-1:0] mem_q [D];
   logic [W-1:0] mem_d [D];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [CW-1:0] cnt_q, cnt_d;
   logic push, pop;
   assign in_ready_out = (cnt_q != CW'(D));
   assign out_valid_out = (cnt_q != '0);
   assign out_data_out = mem_q[rd_q];
   assign push = in_valid_in & in_ready_out;
   assign pop = out_valid_out & out_ready_in;
   always_comb begin
      mem_d = mem_q;
      wr_d = wr_q;
      rd_d = rd_q;
      if (push) begin
         mem_d[wr_q] = in_data_in;
         wr_d = (wr_q == AW'(D - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
         rd_d = (rd_q == AW'(D - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_d = cnt_q + CW'(push) - CW'(pop);
   end
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         mem_q <= '{default: '0};
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         mem_q <= mem_d;
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
      end
   end
endmodule

// What this block does
// - frames run at one of ten baud rates from 110 to 38400 with 7/8 data bits, none/even/odd parity, 1/2 stops.
// - without reconfiguration the port runs the saved settings, else 4800 baud, 8 data bits, no parity, 1 stop, no software flow (button held or saved invalid).
// - a valid configuration command (baud 0..9, parity none/even/odd) sets baud, parity, data bits, stop bits and software flow flag together.
// - a flow flag of 1 turns on xon/xoff flow control and 0 turns it off.
// - the device drives receive data, clear-to-send and ring; the controller drives transmit data, dtr and dsr.
// - the set button held at power-on forces 4800 8n1, and pressing it later does nothing.
module dsp_serial_port
   import dsp_pkg::*;
#(
   parameter int unsigned CLK_HZ = dsp_pkg::CLK_HZ_DEFAULT
) (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic set_btn_in,
   input wire logic [3:0] saved_baud_in,
   input wire logic [1:0] saved_parity_in,
   input wire logic saved_data8_in,
   input wire logic saved_stop2_in,
   input wire logic saved_swflow_in,
   input wire logic cfg_apply_in,
   input wire logic [3:0] cfg_baud_in,
   input wire logic [1:0] cfg_parity_in,
   input wire logic cfg_data8_in,
   input wire logic cfg_stop2_in,
   input wire logic cfg_swflow_in,
   input wire logic ser_txd_in,
   input wire logic ser_dtr_in,
   input wire logic ser_dsr_in,
   input wire logic ring_in,
   output logic ser_rxd_out,
   output logic ser_cts_out,
   output logic ser_ri_out,
   output logic dsr_seen_out,
   input wire logic tx_valid_in,
   input wire logic [dsp_pkg::DATA_W-1:0] tx_data_in,
   output logic tx_ready_out,
   output logic rx_valid_out,
   input wire logic rx_ready_in,
   output logic [dsp_pkg::DATA_W-1:0] rx_data_out,
   output logic rx_err_out,
   output logic tx_paused_out
);
   import dsp_pkg::*;

   // ----------------------------------------------------------------
   // configuration
   // ----------------------------------------------------------------
   logic strap_done_q, strap_done_d;
   logic [3:0] baud_q, baud_d;
   logic [1:0] par_q, par_d;
   logic data8_q, data8_d, stop2_q, stop2_d, swflow_q, swflow_d;
   logic cfg_ok, saved_ok;
   assign cfg_ok = (cfg_baud_in <= BAUD_SEL_MAX) && (cfg_parity_in <= PAR_ODD);
   assign saved_ok = (saved_baud_in <= BAUD_SEL_MAX) && (saved_parity_in <= PAR_ODD);
   always_comb begin
      strap_done_d = 1'b1;
      baud_d = baud_q;
      par_d = par_q;
      data8_d = data8_q;
      stop2_d = stop2_q;
      swflow_d = swflow_q;
      if (!strap_done_q) begin
         if (!set_btn_in && saved_ok) begin
            baud_d = saved_baud_in;
            par_d = saved_parity_in;
            data8_d = saved_data8_in;
            stop2_d = saved_stop2_in;
            swflow_d = saved_swflow_in;
         end else begin
            baud_d = BAUD_SEL_DEFAULT;
            par_d = PAR_DEFAULT;
            data8_d = DATA8_DEFAULT;
            stop2_d = STOP2_DEFAULT;
            swflow_d = SWFLOW_DEFAULT;
         end
      end else if (cfg_apply_in && cfg_ok) begin
         baud_d = cfg_baud_in;
         par_d = cfg_parity_in;
         data8_d = cfg_data8_in;
         stop2_d = cfg_stop2_in;
         swflow_d = cfg_swflow_in;
      end
   end
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         strap_done_q <= 1'b0;
         baud_q <= BAUD_SEL_DEFAULT;
         par_q <= PAR_DEFAULT;
         data8_q <= DATA8_DEFAULT;
         stop2_q <= STOP2_DEFAULT;
         swflow_q <= SWFLOW_DEFAULT;
      end else begin
         strap_done_q <= strap_done_d;
         baud_q <= baud_d;
         par_q <= par_d;
         data8_q <= data8_d;
         stop2_q <= stop2_d;
         swflow_q <= swflow_d;
      end
   end

   // ----------------------------------------------------------------
   // bit timing
   // ----------------------------------------------------------------
   function automatic logic [DIV_W-1:0] div_of(input logic [3:0] sel);
      int unsigned r;
      r = CLK_HZ / BAUD_RATES[(sel <= BAUD_SEL_MAX) ? sel : BAUD_SEL_DEFAULT];
      return r[DIV_W-1:0];
   endfunction
   logic [DIV_W-1:0] bit_div, half_div;
   logic [2:0] last_bit;
   assign bit_div = div_of(baud_q) - 1'b1;
   assign half_div = {1'b0, bit_div[DIV_W-1:1]};
   assign last_bit = data8_q ? LAST_BIT8 : LAST_BIT7;

   // ----------------------------------------------------------------
   // receiver, xon/xoff detection and receive fifo
   // ----------------------------------------------------------------
   dsp_ser_e rx_st_q, rx_st_d;
   logic [DIV_W-1:0] rx_cnt_q, rx_cnt_d;
   logic [2:0] rx_bit_q, rx_bit_d;
   logic [7:0] rx_sh_q, rx_sh_d, rx_byte;
   logic rx_pbit_q, rx_pbit_d, rx_err_q, rx_err_d, paused_q, paused_d, cts_q, cts_d;
   logic rx_fin, rx_bad, rx_push, fifo_in_ready;
   assign rx_byte = data8_q ? rx_sh_q : {1'b0, rx_sh_q[7:1]};
   assign rx_bad = !ser_txd_in || ((par_q != PAR_NONE) && ((^rx_byte ^ rx_pbit_q) != (par_q == PAR_ODD)));
   always_comb begin
      rx_st_d = rx_st_q;
      rx_cnt_d = (rx_cnt_q == '0) ? bit_div : rx_cnt_q - 1'b1;
      rx_bit_d = rx_bit_q;
      rx_sh_d = rx_sh_q;
      rx_pbit_d = rx_pbit_q;
      rx_err_d = 1'b0;
      rx_fin = 1'b0;
      rx_push = 1'b0;
      paused_d = swflow_q ? paused_q : 1'b0;
      case (rx_st_q)
         SER_IDLE: begin
            rx_cnt_d = half_div;
            if (!ser_txd_in) begin
               rx_st_d = SER_START;
            end
         end
         SER_START: begin
            if (rx_cnt_q == '0) begin
               rx_st_d = ser_txd_in ? SER_IDLE : SER_DATA;
               rx_bit_d = '0;
            end
         end
         SER_DATA: begin
            if (rx_cnt_q == '0) begin
               rx_sh_d = {ser_txd_in, rx_sh_q[7:1]};
               rx_bit_d = rx_bit_q + 1'b1;
               if (rx_bit_q == last_bit) begin
                  rx_st_d = (par_q == PAR_NONE) ? SER_STOP : SER_PAR;
               end
            end
         end
         SER_PAR: begin
            if (rx_cnt_q == '0) begin
               rx_pbit_d = ser_txd_in;
               rx_st_d = SER_STOP;
            end
         end
         SER_STOP: begin
            if (rx_cnt_q == '0) begin
               rx_st_d = SER_IDLE;
               rx_fin = 1'b1;
               if (rx_bad) begin
                  rx_err_d = 1'b1;
               end else if (swflow_q && rx_byte == CH_XOFF) begin
                  paused_d = 1'b1;
               end else if (swflow_q && rx_byte == CH_XON) begin
                  paused_d = 1'b0;
               end else if (fifo_in_ready) begin
                  rx_push = 1'b1;
               end else begin
                  rx_err_d = 1'b1;
               end
            end
         end
         default: begin
            rx_st_d = SER_IDLE;
         end
      endcase
      cts_d = fifo_in_ready && !(rx_push && !rx_fin);
   end
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rx_st_q <= SER_IDLE;
         rx_cnt_q <= '0;
         rx_bit_q <= '0;
         rx_sh_q <= '0;
         rx_pbit_q <= 1'b0;
         rx_err_q <= 1'b0;
         paused_q <= 1'b0;
         cts_q <= 1'b0;
      end else begin
         rx_st_q <= rx_st_d;
         rx_cnt_q <= rx_cnt_d;
         rx_bit_q <= rx_bit_d;
         rx_sh_q <= rx_sh_d;
         rx_pbit_q <= rx_pbit_d;
         rx_err_q <= rx_err_d;
         paused_q <= paused_d;
         cts_q <= cts_d;
      end
   end
   dsp_fifo #(.W(DATA_W), .D(FIFO_DEPTH)) u_rx_fifo (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .in_valid_in(rx_push),
      .in_ready_out(fifo_in_ready),
      .in_data_in(rx_byte),
      .out_valid_out(rx_valid_out),
      .out_ready_in(rx_ready_in),
      .out_data_out(rx_data_out)
   );

   // ----------------------------------------------------------------
   // transmitter with dtr or xon/xoff gating
   // ----------------------------------------------------------------
   dsp_ser_e tx_st_q, tx_st_d;
   logic [DIV_W-1:0] tx_cnt_q, tx_cnt_d;
   logic [2:0] tx_bit_q, tx_bit_d;
   logic [7:0] tx_sh_q, tx_sh_d;
   logic tx_pbit_q, tx_pbit_d, txd_q, txd_d, rdy_q, rdy_d, ri_q, dsr_q, tx_take;
   assign tx_take = tx_valid_in && rdy_q;
   always_comb begin
      tx_st_d = tx_st_q;
      tx_cnt_d = (tx_cnt_q == '0) ? bit_div : tx_cnt_q - 1'b1;
      tx_bit_d = tx_bit_q;
      tx_sh_d = tx_sh_q;
      tx_pbit_d = tx_pbit_q;
      txd_d = txd_q;
      case (tx_st_q)
         SER_IDLE: begin
            txd_d = 1'b1;
            tx_cnt_d = bit_div;
            if (tx_take) begin
               tx_st_d = SER_START;
               txd_d = 1'b0;
               tx_sh_d = data8_q ? tx_data_in : {1'b0, tx_data_in[6:0]};
               tx_pbit_d = ^tx_sh_d ^ (par_q == PAR_ODD);
               tx_bit_d = '0;
            end
         end
         SER_START: begin
            if (tx_cnt_q == '0) begin
               tx_st_d = SER_DATA;
               txd_d = tx_sh_q[0];
            end
         end
         SER_DATA: begin
            if (tx_cnt_q == '0) begin
               tx_sh_d = {1'b0, tx_sh_q[7:1]};
               tx_bit_d = tx_bit_q + 1'b1;
               txd_d = tx_sh_d[0];
               if (tx_bit_q == last_bit) begin
                  tx_st_d = (par_q == PAR_NONE) ? SER_STOP : SER_PAR;
                  txd_d = (par_q == PAR_NONE) ? 1'b1 : tx_pbit_q;
                  tx_bit_d = {2'h0, stop2_q};
               end
            end
         end
         SER_PAR: begin
            if (tx_cnt_q == '0) begin
               tx_st_d = SER_STOP;
               txd_d = 1'b1;
            end
         end
         SER_STOP: begin
            if (tx_cnt_q == '0) begin
               tx_bit_d = tx_bit_q - 1'b1;
               if (tx_bit_q == '0) begin
                  tx_st_d = SER_IDLE;
               end
            end
         end
         default: begin
            tx_st_d = SER_IDLE;
         end
      endcase
      rdy_d = (tx_st_d == SER_IDLE) && (swflow_d ? !paused_d : ser_dtr_in);
   end
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         tx_st_q <= SER_IDLE;
         tx_cnt_q <= '0;
         tx_bit_q <= '0;
         tx_sh_q <= '0;
         tx_pbit_q <= 1'b0;
         txd_q <= 1'b1;
         rdy_q <= 1'b0;
         ri_q <= 1'b0;
         dsr_q <= 1'b0;
      end else begin
         tx_st_q <= tx_st_d;
         tx_cnt_q <= tx_cnt_d;
         tx_bit_q <= tx_bit_d;
         tx_sh_q <= tx_sh_d;
         tx_pbit_q <= tx_pbit_d;
         txd_q <= txd_d;
         rdy_q <= rdy_d;
         ri_q <= ring_in;
         dsr_q <= ser_dsr_in;
      end
   end
   assign ser_rxd_out = txd_q;
   assign ser_cts_out = cts_q;
   assign ser_ri_out = ri_q;
   assign dsr_seen_out = dsr_q;
   assign tx_ready_out = rdy_q;
   assign rx_err_out = rx_err_q;
   assign tx_paused_out = paused_q;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   a_strap_default: assert property (!strap_done_q && set_btn_in |=> baud_q == BAUD_SEL_DEFAULT && data8_q
      && par_q == PAR_NONE && !stop2_q && !swflow_q) else $error("set button did not force defaults");
   a_button_late: assert property (strap_done_q && !cfg_apply_in |=> $stable(baud_q) && $stable(par_q))
      else $error("config changed without command");
   a_apply_cfg: assert property (strap_done_q && cfg_apply_in && cfg_ok |=> baud_q == $past(cfg_baud_in)
      && swflow_q == $past(cfg_swflow_in)) else $error("config command not applied");
   a_bad_cfg: assert property (strap_done_q && cfg_apply_in && !cfg_ok |=> $stable(baud_q))
      else $error("invalid config applied");
   a_xoff_pause: assert property (rx_fin && !rx_bad && swflow_q && rx_byte == CH_XOFF |-> !rx_push ##1 paused_q)
      else $error("xoff not acted on");
   a_xon_resume: assert property (rx_fin && !rx_bad && swflow_q && rx_byte == CH_XON |-> !rx_push ##1 !paused_q)
      else $error("xon not acted on");
   a_pause_block: assert property (swflow_q && paused_q |-> !tx_ready_out)
      else $error("transmit offered while paused");
   a_dtr_block: assert property (!swflow_q && tx_ready_out |-> $past(ser_dtr_in))
      else $error("transmit offered without dtr");
   a_start_bit: assert property (tx_take |=> !ser_rxd_out && tx_st_q == SER_START)
      else $error("start bit missing");
   a_cts_full: assert property (!fifo_in_ready |=> !ser_cts_out)
      else $error("cts high with full fifo");
   c_tx_frame: cover property (tx_take ##1 tx_st_q == SER_START);
   c_rx_push: cover property (rx_push);
   c_xoff_seen: cover property (swflow_q && $rose(paused_q));
   c_cfg_apply: cover property (strap_done_q && cfg_apply_in && cfg_ok);
endmodule

`default_nettype wire

// ### verilog/dsp_pkg.sv
// constants, encodings and state types for the serial dte port
// assumes a single clock; baud divisors are derived from the clock rate in the top module
package dsp_pkg;
   // ----------------------------------------------------------------
   // baud rates, index 0..9
   // ----------------------------------------------------------------
   localparam int unsigned BAUD_N = 10;
   localparam int unsigned BAUD_RATES [BAUD_N] = '{110, 150, 300, 600, 1200, 2400, 4800, 9600, 19200, 38400};
   localparam int unsigned CLK_HZ_DEFAULT = 10_000_000;
   localparam int DIV_W = 17;
   // ----------------------------------------------------------------
   // frame encodings and factory defaults
   // ----------------------------------------------------------------
   localparam logic [1:0] PAR_NONE = 2'h0;
   localparam logic [1:0] PAR_EVEN = 2'h1;
   localparam logic [1:0] PAR_ODD = 2'h2;
   localparam logic [3:0] BAUD_SEL_DEFAULT = 4'h6;
   localparam logic [3:0] BAUD_SEL_MAX = 4'h9;
   localparam logic [1:0] PAR_DEFAULT = PAR_NONE;
   localparam logic DATA8_DEFAULT = 1'b1;
   localparam logic STOP2_DEFAULT = 1'b0;
   localparam logic SWFLOW_DEFAULT = 1'b0;
   localparam logic [2:0] LAST_BIT8 = 3'h7;
   localparam logic [2:0] LAST_BIT7 = 3'h6;
   localparam logic [7:0] CH_XON = 8'h11;
   localparam logic [7:0] CH_XOFF = 8'h13;
   localparam int FIFO_DEPTH = 8;
   localparam int DATA_W = 8;
   // ----------------------------------------------------------------
   // frame state machine
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      SER_IDLE = 3'h0,
      SER_START = 3'h1,
      SER_DATA = 3'h2,
      SER_PAR = 3'h3,
      SER_STOP = 3'h4
   } dsp_ser_e;
endpackage

// ### tb/dsp_ctrl_model.sv
// controller model: async serial terminal at the far end of the dte link
// assumes its tasks are called by the bench right after a rising edge of ref_clk_in
`timescale 1ns/100ps
`default_nettype none
module dsp_ctrl_model
   import dsp_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic rxd_in,
   output logic txd_out,
   output logic dtr_out,
   output logic dsr_out
);
   initial begin
      txd_out = 1'b1;
      dtr_out = 1'b1;
      dsr_out = 1'b0;
   end
   // ----------------------------------------------------------------
   // one frame toward the device, lsb first, parity optionally corrupted
   // ----------------------------------------------------------------
   task automatic send(input logic [7:0] d, input int dv, input logic [1:0] p, input logic d8, input logic s2,
                       input logic bad);
      logic [7:0] m;
      int k;
      m = d8 ? d : {1'b0, d[6:0]};
      txd_out <= 1'b0;
      repeat (dv) @(posedge ref_clk_in);
      for (k = 0; k < (d8 ? 8 : 7); k++) begin
         txd_out <= m[k];
         repeat (dv) @(posedge ref_clk_in);
      end
      if (p != PAR_NONE) begin
         txd_out <= ^m ^ (p == PAR_ODD) ^ bad;
         repeat (dv) @(posedge ref_clk_in);
      end
      txd_out <= 1'b1;
      repeat (s2 ? 2 * dv : dv) @(posedge ref_clk_in);
   endtask
   // ----------------------------------------------------------------
   // one frame from the device, sampled at bit centres
   // ----------------------------------------------------------------
   task automatic recv(input int dv, input logic [1:0] p, input logic d8, input logic s2,
                       output logic [7:0] d, output logic ok);
      int k;
      d = 8'h00;
      for (k = 0; k < 3000 && rxd_in !== 1'b0; k++) @(posedge ref_clk_in);
      repeat (dv / 2) @(posedge ref_clk_in);
      ok = (rxd_in === 1'b0);
      for (k = 0; k < (d8 ? 8 : 7); k++) begin
         repeat (dv) @(posedge ref_clk_in);
         d[k] = rxd_in;
      end
      if (p != PAR_NONE) begin
         repeat (dv) @(posedge ref_clk_in);
         ok = ok && (rxd_in === (^d ^ (p == PAR_ODD)));
      end
      for (k = 0; k < (s2 ? 2 : 1); k++) begin
         repeat (dv) @(posedge ref_clk_in);
         ok = ok && (rxd_in === 1'b1);
      end
   endtask
endmodule
`default_nettype wire

// ### tb/tb_dsp_serial_port.sv
// bench for the serial dte port: byte exchanges through the controller model
// assumes CLK_HZ lowered so that 4800 baud is 40 clocks a bit
`timescale 1ns/100ps
`default_nettype none
module tb_dsp_serial_port;
   import dsp_pkg::*;
   localparam int unsigned CLK = 192_000;
   logic ref_clk_in, rst_in, set_btn_in, cfg_apply_in, cfg_data8_in, cfg_stop2_in, cfg_swflow_in;
   logic [3:0] cfg_baud_in;
   logic [1:0] cfg_parity_in;
   logic ring_in, tx_valid_in, rx_ready_in, txd, dtr, dsr;
   logic [7:0] tx_data_in, rx_data_out;
   logic rxd, cts, ri, dsr_seen, tx_ready_out, rx_valid_out, rx_err_out, tx_paused_out;
   int num_errors = 0, tests_run = 0, err_cnt = 0, e0;
   logic [3:0] cb = 4'h6;
   logic [3:0] sv_b = 4'h7;
   logic [1:0] cp = PAR_NONE;
   logic c8 = 1'b1, cs = 1'b0;
   logic [7:0] got;
   dsp_serial_port #(.CLK_HZ(CLK)) dsp_serial_port_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
      .set_btn_in(set_btn_in), .saved_baud_in(sv_b), .saved_parity_in(PAR_ODD), .saved_data8_in(1'b0),
      .saved_stop2_in(1'b1), .saved_swflow_in(1'b0), .cfg_apply_in(cfg_apply_in), .cfg_baud_in(cfg_baud_in),
      .cfg_parity_in(cfg_parity_in), .cfg_data8_in(cfg_data8_in), .cfg_stop2_in(cfg_stop2_in),
      .cfg_swflow_in(cfg_swflow_in), .ser_txd_in(txd), .ser_dtr_in(dtr), .ser_dsr_in(dsr), .ring_in(ring_in),
      .ser_rxd_out(rxd), .ser_cts_out(cts), .ser_ri_out(ri), .dsr_seen_out(dsr_seen), .tx_valid_in(tx_valid_in),
      .tx_data_in(tx_data_in), .tx_ready_out(tx_ready_out), .rx_valid_out(rx_valid_out),
      .rx_ready_in(rx_ready_in), .rx_data_out(rx_data_out), .rx_err_out(rx_err_out),
      .tx_paused_out(tx_paused_out));
   dsp_ctrl_model dsp_ctrl_model_inst (.ref_clk_in(ref_clk_in), .rxd_in(rxd), .txd_out(txd), .dtr_out(dtr),
      .dsr_out(dsr));
   initial begin
      ref_clk_in = 1'b0;
      forever #50 ref_clk_in = ~ref_clk_in;
   end
   always @(posedge ref_clk_in) if (rx_err_out === 1'b1) err_cnt <= err_cnt + 1;
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic do_reset(input logic btn);
      set_btn_in <= btn;
      rst_in <= 1'b1;
      repeat (3) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      repeat (3) @(posedge ref_clk_in);
   endtask
   task automatic cfg(input logic [3:0] b, input logic [1:0] p, input logic d8, input logic s2, input logic sw);
      cfg_baud_in <= b;
      cfg_parity_in <= p;
      cfg_data8_in <= d8;
      cfg_stop2_in <= s2;
      cfg_swflow_in <= sw;
      cfg_apply_in <= 1'b1;
      @(posedge ref_clk_in);
      cfg_apply_in <= 1'b0;
      @(posedge ref_clk_in);
      if (b <= BAUD_SEL_MAX && p <= PAR_ODD) begin
         {cb, cp, c8, cs} = {b, p, d8, s2};
      end
   endtask
   task automatic pop(output logic [7:0] d);
      int t;
      rx_ready_in <= 1'b1;
      for (t = 0; t < 2000; t++) begin
         @(posedge ref_clk_in);
         if (rx_valid_out === 1'b1) break;
      end
      d = rx_data_out;
      rx_ready_in <= 1'b0;
      @(posedge ref_clk_in);
      if (t == 2000) begin
         num_errors++;
         stop_test();
      end
   endtask
   task automatic tx_byte(input logic [7:0] d);
      int t;
      tx_valid_in <= 1'b1;
      tx_data_in <= d;
      for (t = 0; t < 4000; t++) begin
         @(posedge ref_clk_in);
         if (tx_ready_out === 1'b1) break;
      end
      tx_valid_in <= 1'b0;
      if (t == 4000) begin
         num_errors++;
         stop_test();
      end
   endtask
   task automatic exchange(input logic [7:0] d);
      logic [7:0] m;
      logic ok;
      int dv;
      dv = CLK / BAUD_RATES[cb];
      m = c8 ? d : {1'b0, d[6:0]};
      dsp_ctrl_model_inst.send(d, dv, cp, c8, cs, 1'b0);
      pop(got);
      check("rx_data", got, m);
      fork
         tx_byte(d);
         dsp_ctrl_model_inst.recv(dv, cp, c8, cs, got, ok);
      join
      check("tx_data", got, m);
      check("tx_frame", {7'h00, ok}, 8'h01);
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      repeat (60000) @(posedge ref_clk_in);
      num_errors++;
      stop_test();
   end
   initial begin
      {cfg_apply_in, cfg_baud_in, cfg_parity_in} = {1'b0, 4'h0, 2'h0};
      {cfg_data8_in, cfg_stop2_in, cfg_swflow_in, ring_in, tx_valid_in, rx_ready_in} = 6'h00;
      tx_data_in = 8'h00;
      do_reset(1'b1);
      check("cts", cts, 1);
      exchange(8'hA5);
      do_reset(1'b0);
      {cb, cp, c8, cs} = {4'h7, PAR_ODD, 1'b0, 1'b1};
      exchange(8'hC3);
      set_btn_in <= 1'b1;
      exchange(8'h5A);
      ring_in <= 1'b1;
      dsp_ctrl_model_inst.dsr_out <= 1'b1;
      @(posedge ref_clk_in);
      check("ri_dsr_early", {6'h00, ri, dsr_seen}, 8'h00);
      @(posedge ref_clk_in);
      check("ri_dsr", {6'h00, ri, dsr_seen}, 8'h03);
      cfg(4'h6, PAR_NONE, 1'b1, 1'b0, 1'b0);
      exchange(8'h3C);
      cfg(4'h8, PAR_EVEN, 1'b0, 1'b1, 1'b0);
      exchange(8'hF1);
      cfg(4'hA, PAR_ODD, 1'b1, 1'b0, 1'b0);
      exchange(8'h96);
      cfg(4'h9, PAR_ODD, 1'b1, 1'b0, 1'b0);
      exchange(8'h69);
      e0 = err_cnt;
      dsp_ctrl_model_inst.send(8'h22, 5, PAR_ODD, 1'b1, 1'b0, 1'b1);
      repeat (3) @(posedge ref_clk_in);
      check("parity_err", 8'(err_cnt - e0), 8'h01);
      check("bad_dropped", {7'h00, rx_valid_out}, 8'h00);
      cfg(4'h9, PAR_NONE, 1'b1, 1'b0, 1'b0);
      for (int i = 0; i < FIFO_DEPTH; i++) dsp_ctrl_model_inst.send(8'(i * 17 + 1), 5, PAR_NONE, 1'b1, 1'b0, 1'b0);
      repeat (3) @(posedge ref_clk_in);
      check("cts_full", {7'h00, cts}, 8'h00);
      e0 = err_cnt;
      dsp_ctrl_model_inst.send(8'hEE, 5, PAR_NONE, 1'b1, 1'b0, 1'b0);
      repeat (3) @(posedge ref_clk_in);
      check("overrun", 8'(err_cnt - e0), 8'h01);
      for (int i = 0; i < FIFO_DEPTH; i++) begin
         pop(got);
         check("fifo_order", got, 8'(i * 17 + 1));
      end
      repeat (3) @(posedge ref_clk_in);
      check("drained", {6'h00, rx_valid_out, cts}, 8'h01);
      dsp_ctrl_model_inst.dtr_out <= 1'b0;
      repeat (3) @(posedge ref_clk_in);
      check("dtr_gate", {7'h00, tx_ready_out}, 8'h00);
      dsp_ctrl_model_inst.dtr_out <= 1'b1;
      cfg(4'h9, PAR_NONE, 1'b1, 1'b0, 1'b1);
      dsp_ctrl_model_inst.send(CH_XOFF, 5, PAR_NONE, 1'b1, 1'b0, 1'b0);
      repeat (3) @(posedge ref_clk_in);
      check("paused", {6'h00, tx_paused_out, tx_ready_out}, 8'h02);
      check("xoff_eaten", {7'h00, rx_valid_out}, 8'h00);
      fork
         exchange(8'h42);
         begin
            repeat (200) @(posedge ref_clk_in);
            check("held_line", {7'h00, rxd}, 8'h01);
            dsp_ctrl_model_inst.send(CH_XON, 5, PAR_NONE, 1'b1, 1'b0, 1'b0);
         end
      join
      check("resumed", {7'h00, tx_paused_out}, 8'h00);
      sv_b <= 4'hF;
      do_reset(1'b0);
      {cb, cp, c8, cs} = {BAUD_SEL_DEFAULT, PAR_NONE, 1'b1, 1'b0};
      exchange(8'hB4);
      stop_test();
   end
endmodule
`default_nettype wire
